// ### core/level_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a quasi-static level; multi-bit words must be held stable.
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // One flop pair per bit; the first flop feeds only the second
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        meta_reg[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end
      else
      begin
        meta_reg[i] <= async_in[i];
        sync_out[i] <= meta_reg[i];
      end
    end
  end
endmodule : level_sync

// ### core/offer_power_calc.sv
// Computes the live contract power in 0.5 W units from the selected offer.
// Assumes voltage in 100 mV steps and current in 50 mA steps, core clock domain.
`timescale 1ns/1ps
`include "pd_status_defs.svh"
module offer_power_calc (
  input wire logic core_clk,
  input wire logic resetn,
  offer_power_if.calc pw
);
  import pd_status_pkg::*;

  // Product divided down to 0.5 W units, saturating at a full byte
  function automatic reg_byte_t half_watts(input logic [7:0] volts, input logic [6:0] amps);
    logic [14:0] prod;
    logic [14:0] quot;
    prod = volts * amps;
    quot = prod / `POWER_UNIT_DIV;
    if (quot > `POWER_SAT_LIMIT)
      half_watts = 8'hFF;
    else
      half_watts = quot[7:0];
  endfunction : half_watts

  // Not latched: follows the offer every cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pw.power <= 8'h00;
    else if (pw.offer_index == 3'h0)
      pw.power <= pw.rp_high ? `POWER_DEFAULT_HIGH : `POWER_DEFAULT_LOW;
    else
      pw.power <= half_watts(pw.offer_voltage, pw.offer_current);
  end
endmodule : offer_power_calc

// ### core/offer_power_if.sv
// Carries the live offer figures to the power calculator and its result back.
// Assumes all members live in the core clock domain.
`timescale 1ns/1ps
interface offer_power_if;
  logic [2:0] offer_index;
  logic [7:0] offer_voltage;
  logic [6:0] offer_current;
  logic rp_high;
  pd_status_pkg::reg_byte_t power;
  modport calc (input offer_index, input offer_voltage, input offer_current, input rp_high, output power);
  modport user (output offer_index, output offer_voltage, output offer_current, output rp_high, input power);
endinterface : offer_power_if

// ### core/pd_port_status_register_bank.sv
// Status, identification and clock-enable registers behind a serial target link.
// Assumes status inputs are asynchronous levels; link_clk oversamples the link pins.
//
// What this block does
// - Port status bit 7 shows sink sink_present
// - Port status bit 5 shows plug orientation
// - Port status bit 4 flags battery short
// - Port status bit 3 flags any fault
// - Port status bit 2 shows configuration page
// - Port status bit 1 shows current limiting
// - Bits 0 and 6 show thermistor events
// - Event flags at 0x31 clear on read
// - Event bits 7,6 latch low supply
// - Event bits 5,4 latch temperature warnings
// - Event bits 3:1 hold selected offer index
// - Event bit 0 holds offer kind
// - Contract power live in half-watt steps
// - No contract gives 7.5W or 15W
// - Info bits 7,6 show mismatch and giveback
// - Info bit 5 cable rating, 4:0 firmware
// - Requested current in 20mA steps, conditionally valid
// - Maker and part codes follow requested current
// - Stop write ignored while clock off; start write or attach starts it
// - Clock enable bit self-clears after start
// - Clock stops on write 0, EN, UVLO
// - Port status at 0x30 returns one byte
`timescale 1ns/1ps
`include "pd_status_defs.svh"
module pd_port_status_register_bank (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sink_present,
  input wire logic second_thermistor_event,
  input wire logic plug_orientation,
  input wire logic battery_short_flag,
  input wire logic over_current,
  input wire logic over_temperature,
  input wire logic config_page,
  input wire logic current_limit_state,
  input wire logic thermistor_event,
  input wire logic supply_low_first_flag,
  input wire logic supply_low_second_flag,
  input wire logic temp_warning_first,
  input wire logic temp_warning_second,
  input wire logic [2:0] selected_offer_index,
  input wire logic offer_kind,
  input wire logic [7:0] offer_voltage,
  input wire logic [6:0] offer_current,
  input wire logic pullup_high,
  input wire logic capability_mismatch,
  input wire logic power_return_request,
  input wire logic cable_current_rating,
  input wire pd_status_pkg::reg_byte_t requested_current_limit,
  input wire logic enable_ctrl,
  input wire logic supply_uvlo,
  output logic digital_clock_on
);
  import pd_status_pkg::*;

  localparam int STAT_W = 46;

  //////////////////////////////////////////////////////////////////////////////
  // Core-domain input synchronisation

  logic [STAT_W-1:0] stat_raw;
  logic [STAT_W-1:0] stat_sync;
  logic sink_s, therm2_s, orient_s, short_s, oc_s, ot_s, page_s, cc_s, therm1_s;
  logic low1_s, low2_s, tw1_s, tw2_s, kind_s, rp_s, mism_s, give_s, cable_s, en_s, uvlo_s;
  logic [2:0] idx_s;
  logic [7:0] volt_s;
  logic [6:0] curr_s;
  reg_byte_t reqcur_s;

  // Every pin-level status passes two flops before any decode
  assign stat_raw = {sink_present, second_thermistor_event, plug_orientation, battery_short_flag,
                     over_current, over_temperature, config_page, current_limit_state, thermistor_event,
                     supply_low_first_flag, supply_low_second_flag, temp_warning_first, temp_warning_second,
                     selected_offer_index, offer_kind, offer_voltage, offer_current, pullup_high,
                     capability_mismatch, power_return_request, cable_current_rating, requested_current_limit,
                     enable_ctrl, supply_uvlo};
  assign {sink_s, therm2_s, orient_s, short_s, oc_s, ot_s, page_s, cc_s, therm1_s,
          low1_s, low2_s, tw1_s, tw2_s, idx_s, kind_s, volt_s, curr_s, rp_s,
          mism_s, give_s, cable_s, reqcur_s, en_s, uvlo_s} = stat_sync;

  level_sync #(.WIDTH(STAT_W)) u_stat_sync (
    .clk(core_clk),
    .resetn(resetn),
    .async_in(stat_raw),
    .sync_out(stat_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: pin sampling and condition detect

  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // Inverted through the sync so both lines read high out of reset, like an idle bus, and no false edge follows
  level_sync #(.WIDTH(2)) u_pin_sync (
    .clk(link_clk),
    .resetn(resetn),
    .async_in(~{scl_in, sda_in}),
    .sync_out(pins_s)
  );
  assign {scl_s, sda_s} = ~pins_s;

  // Third flop for edge detect, never the metastable stage
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: byte engine

  link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  reg_byte_t shift_reg, tx_reg, ptr_reg, rx_reg;
  logic rw_reg, host_ack_reg, sda_oe_reg;
  logic issue_read, issue_write;

  // Prefetch starts at the rising edge of the acknowledge slot so the byte is back before the falling edge
  always_comb
  begin
    issue_read = scl_rise & (((state_reg == LINK_ADDR_ACK) & rw_reg) | ((state_reg == LINK_RDATA_ACK) & ~sda_s));
    issue_write = scl_fall & (state_reg == LINK_WDATA) & (bit_cnt_reg == `BYTE_BITS);
  end

  // Bit-level protocol; start and stop override everything
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= LINK_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      state_reg <= LINK_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_reg <= LINK_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_reg)
        LINK_ADDR, LINK_PTR, LINK_WDATA:
        begin
          shift_reg <= {shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        LINK_RDATA: bit_cnt_reg <= bit_cnt_reg + 4'h1;
        LINK_RDATA_ACK: host_ack_reg <= ~sda_s;
        default: bit_cnt_reg <= bit_cnt_reg;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_reg)
        LINK_ADDR:
        begin
          if (bit_cnt_reg == `BYTE_BITS)
          begin
            bit_cnt_reg <= 4'h0;
            rw_reg <= shift_reg[0];
            state_reg <= (shift_reg[7:1] == `TARGET_ADDR) ? LINK_ADDR_ACK : LINK_IDLE;
            sda_oe_reg <= (shift_reg[7:1] == `TARGET_ADDR);
          end
        end
        LINK_ADDR_ACK:
        begin
          state_reg <= rw_reg ? LINK_RDATA : LINK_PTR;
          tx_reg <= rx_reg;
          sda_oe_reg <= rw_reg & ~rx_reg[7];
        end
        LINK_PTR, LINK_WDATA:
        begin
          if (bit_cnt_reg == `BYTE_BITS)
          begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b1;
            state_reg <= (state_reg == LINK_PTR) ? LINK_PTR_ACK : LINK_WDATA_ACK;
            ptr_reg <= (state_reg == LINK_PTR) ? shift_reg : ptr_reg + 8'h01;
          end
        end
        LINK_PTR_ACK, LINK_WDATA_ACK:
        begin
          state_reg <= LINK_WDATA;
          sda_oe_reg <= 1'b0;
        end
        LINK_RDATA:
        begin
          if (bit_cnt_reg == `BYTE_BITS)
          begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            ptr_reg <= ptr_reg + 8'h01;
            state_reg <= LINK_RDATA_ACK;
          end
          else
          begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= ~tx_reg[6];
          end
        end
        LINK_RDATA_ACK:
        begin
          state_reg <= host_ack_reg ? LINK_RDATA : LINK_IDLE;
          tx_reg <= rx_reg;
          sda_oe_reg <= host_ack_reg & ~rx_reg[7];
        end
        default: state_reg <= LINK_IDLE;
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Request handshake between the domains

  logic req_tgl_reg, req_write_reg, req_s, req_d_reg, new_req;
  logic ack_tgl_reg, ack_s, ack_seen_reg;
  reg_byte_t req_addr_reg, req_wdata_reg, rdata_reg;

  // Address and data hold still until the next toggle, so the core may read them after sync
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_tgl_reg <= 1'b0;
      req_write_reg <= 1'b0;
      req_addr_reg <= 8'h00;
      req_wdata_reg <= 8'h00;
    end
    else if (issue_write | issue_read)
    begin
      req_tgl_reg <= ~req_tgl_reg;
      req_write_reg <= issue_write;
      req_addr_reg <= ptr_reg;
      req_wdata_reg <= shift_reg;
    end
  end

  level_sync #(.WIDTH(1)) u_req_sync (
    .clk(core_clk),
    .resetn(resetn),
    .async_in(req_tgl_reg),
    .sync_out(req_s)
  );
  level_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .resetn(resetn),
    .async_in(ack_tgl_reg),
    .sync_out(ack_s)
  );

  // Answer byte taken once the returning toggle is seen
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_seen_reg <= 1'b0;
      rx_reg <= `RDATA_RST;
    end
    else if (ack_s != ack_seen_reg)
    begin
      ack_seen_reg <= ack_s;
      rx_reg <= rdata_reg;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      req_d_reg <= 1'b0;
    else
      req_d_reg <= req_s;
  end
  assign new_req = req_s ^ req_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: registers

  reg_byte_t port_status_w, event_flags_reg, negotiation_w, req_current_w, read_mux_w;
  logic rd_flags, wr_clock, clk_enable_bit_reg, clk_on_reg, sink_d_reg, attach_rise;
  offer_power_if pw_if();

  assign pw_if.offer_index = idx_s;
  assign pw_if.offer_voltage = volt_s;
  assign pw_if.offer_current = curr_s;
  assign pw_if.rp_high = rp_s;

  offer_power_calc u_power (
    .core_clk(core_clk),
    .resetn(resetn),
    .pw(pw_if.calc)
  );

  // Live port status; fault covers over-current, over-temperature and any battery short
  always_comb
  begin
    port_status_w = 8'h00;
    port_status_w[`PS_SINK_PRESENT_BIT] = sink_s;
    port_status_w[`PS_THERM_SECOND_BIT] = therm2_s;
    port_status_w[`PS_ORIENTATION_BIT] = orient_s;
    port_status_w[`PS_BATT_SHORT_BIT] = short_s;
    port_status_w[`PS_FAULT_BIT] = oc_s | ot_s | short_s;
    port_status_w[`PS_CONFIG_PAGE_BIT] = page_s;
    port_status_w[`PS_CURRENT_LIMIT_BIT] = cc_s;
    port_status_w[`PS_THERM_FIRST_BIT] = therm1_s;
  end

  // Requested current only means something for an unreturned fixed offer with mismatch set
  assign negotiation_w = {mism_s, give_s, cable_s, `FW_REVISION_VAL};
  assign req_current_w = (!give_s && !kind_s && idx_s != 3'h0 && mism_s) ? reqcur_s : 8'h00;

  // Read decode; unmapped and write-only offsets read as zero
  always_comb
  begin
    case (req_addr_reg)
      `PORT_STATUS_OFS: read_mux_w = port_status_w;
      `EVENT_FLAGS_OFS: read_mux_w = event_flags_reg;
      `CONTRACT_POWER_OFS: read_mux_w = pw_if.power;
      `CONFIG_SUFFIX_OFS: read_mux_w = `CONFIG_SUFFIX_VAL;
      `CONFIG_REVISION_OFS: read_mux_w = `CONFIG_REVISION_VAL;
      `NEGOTIATION_INFO_OFS: read_mux_w = negotiation_w;
      `REQUESTED_CURRENT_OFS: read_mux_w = req_current_w;
      `MAKER_CODE_OFS: read_mux_w = `MAKER_CODE_VAL;
      `PART_CODE_OFS: read_mux_w = `PART_CODE_VAL;
      default: read_mux_w = 8'h00;
    endcase
  end

  assign rd_flags = new_req & ~req_write_reg & (req_addr_reg == `EVENT_FLAGS_OFS);
  // Only the clock enable offset has a write effect; all others fall through untouched
  assign wr_clock = new_req & req_write_reg & (req_addr_reg == `CORE_CLOCK_ENABLE_OFS);

  // Answer the link and return the toggle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= `RDATA_RST;
      ack_tgl_reg <= 1'b0;
    end
    else if (new_req)
    begin
      ack_tgl_reg <= req_s;
      if (!req_write_reg)
        rdata_reg <= read_mux_w;
    end
  end

  // Sticky flags: a new event in the read cycle survives the clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      event_flags_reg <= `EVENT_FLAGS_RST;
    else
    begin
      event_flags_reg[`EF_SUPPLY_LOW_FIRST_BIT] <= (event_flags_reg[`EF_SUPPLY_LOW_FIRST_BIT] & ~rd_flags) | low1_s;
      event_flags_reg[`EF_SUPPLY_LOW_SECOND_BIT] <= (event_flags_reg[`EF_SUPPLY_LOW_SECOND_BIT] & ~rd_flags) | low2_s;
      event_flags_reg[`EF_TEMP_FIRST_BIT] <= (event_flags_reg[`EF_TEMP_FIRST_BIT] & ~rd_flags) | tw1_s;
      event_flags_reg[`EF_TEMP_SECOND_BIT] <= (event_flags_reg[`EF_TEMP_SECOND_BIT] & ~rd_flags) | tw2_s;
      if (idx_s != 3'h0)
      begin
        event_flags_reg[`EF_INDEX_MSB:`EF_INDEX_LSB] <= idx_s;
        event_flags_reg[`EF_KIND_BIT] <= kind_s;
      end
      else if (rd_flags)
      begin
        event_flags_reg[`EF_INDEX_MSB:`EF_INDEX_LSB] <= 3'h0;
        event_flags_reg[`EF_KIND_BIT] <= 1'b0;
      end
    end
  end

  // Enable bit lives one cycle: it starts the clock, then drops back
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      clk_enable_bit_reg <= 1'b0;
    else
      clk_enable_bit_reg <= wr_clock & (req_wdata_reg == `CLOCK_ON_CMD);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      sink_d_reg <= 1'b0;
    else
      sink_d_reg <= sink_s;
  end
  assign attach_rise = sink_s & ~sink_d_reg;

  // EN or UVLO win over any start; a stop write counts only while running
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      clk_on_reg <= 1'b0;
    else if (!en_s || uvlo_s)
      clk_on_reg <= 1'b0;
    else if (clk_on_reg && wr_clock && req_wdata_reg == `CLOCK_OFF_CMD)
      clk_on_reg <= 1'b0;
    else if (clk_enable_bit_reg || attach_rise)
      clk_on_reg <= 1'b1;
  end
  assign digital_clock_on = clk_on_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  port_status_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (new_req && !req_write_reg && req_addr_reg == `PORT_STATUS_OFS) |=> (rdata_reg[7] == $past(sink_s)))
    else $error("port status read does not show attach");
  flags_read_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_flags && !low1_s && !low2_s && !tw1_s && !tw2_s && idx_s == 3'h0) |=> (event_flags_reg == 8'h00))
    else $error("event flags not cleared by read");
  supply_low_latch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    low1_s ##1 (!low1_s && !rd_flags) |=> event_flags_reg[7])
    else $error("first supply low flag lost");
  temp_warn_latch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (tw2_s && rd_flags) |=> event_flags_reg[4])
    else $error("temperature warning lost on read");
  offer_index_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (idx_s != 3'h0) |=> (event_flags_reg[3:1] == $past(idx_s)))
    else $error("offer index not captured");
  default_power_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (idx_s == 3'h0 && rp_s) |=> (pw_if.power == 8'h1E))
    else $error("no-contract power wrong");
  clock_self_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_enable_bit_reg |=> !clk_enable_bit_reg)
    else $error("clock enable bit did not clear");
  clock_start_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_enable_bit_reg && en_s && !uvlo_s) |=> clk_on_reg)
    else $error("clock did not start");
  clock_stop_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!en_s || uvlo_s) |=> !clk_on_reg)
    else $error("clock still on after disable");
  addr_ack_drive_a: assert property (@(posedge link_clk) disable iff (!resetn)
    (state_reg == LINK_ADDR_ACK) |-> sda_oe_reg)
    else $error("address not acknowledged");
endmodule : pd_port_status_register_bank

// ### core/pd_status_defs.svh
// Offsets, field positions, reset values and fixed codes of the port status bank.
// Assumes it is included by bare name from files that read these registers.
`ifndef PD_STATUS_DEFS_SVH
`define PD_STATUS_DEFS_SVH

// Register offsets on the serial target link
`define PORT_STATUS_OFS 8'h30
`define EVENT_FLAGS_OFS 8'h31
`define CONTRACT_POWER_OFS 8'h32
`define CONFIG_SUFFIX_OFS 8'h33
`define CONFIG_REVISION_OFS 8'h34
`define NEGOTIATION_INFO_OFS 8'h35
`define REQUESTED_CURRENT_OFS 8'h36
`define MAKER_CODE_OFS 8'h37
`define PART_CODE_OFS 8'h38
`define CORE_CLOCK_ENABLE_OFS 8'h39

// Port status field positions
`define PS_SINK_PRESENT_BIT 7
`define PS_THERM_SECOND_BIT 6
`define PS_ORIENTATION_BIT 5
`define PS_BATT_SHORT_BIT 4
`define PS_FAULT_BIT 3
`define PS_CONFIG_PAGE_BIT 2
`define PS_CURRENT_LIMIT_BIT 1
`define PS_THERM_FIRST_BIT 0

// Event flag field positions
`define EF_SUPPLY_LOW_FIRST_BIT 7
`define EF_SUPPLY_LOW_SECOND_BIT 6
`define EF_TEMP_FIRST_BIT 5
`define EF_TEMP_SECOND_BIT 4
`define EF_INDEX_MSB 3
`define EF_INDEX_LSB 1
`define EF_KIND_BIT 0

// Reset values and commands
`define EVENT_FLAGS_RST 8'h00
`define RDATA_RST 8'h00
`define CLOCK_ON_CMD 8'h01
`define CLOCK_OFF_CMD 8'h00

// Fixed codes; all values arbitrary
`define CONFIG_SUFFIX_VAL 8'hA5
`define CONFIG_REVISION_VAL 8'h03
`define MAKER_CODE_VAL 8'h5C
`define PART_CODE_VAL 8'h3E
`define FW_REVISION_VAL 5'h03

// Link constants
`define TARGET_ADDR 7'h61
`define BYTE_BITS 4'h8

// Power in 0.5 W units: 100 mV x 50 mA = 5 mW, 100 of them per unit
`define POWER_UNIT_DIV 15'h0064
`define POWER_SAT_LIMIT 15'h00FF
`define POWER_DEFAULT_LOW 8'h0F
`define POWER_DEFAULT_HIGH 8'h1E

`endif

// ### core/pd_status_pkg.sv
// Types shared by the port status bank and its helpers.
// Assumes the constants header provides all numeric values.
package pd_status_pkg;
  typedef logic [7:0] reg_byte_t;
  // Serial target states, gray coded along the write path; LINK_ADDR_ACK to LINK_RDATA changes three bits
  typedef enum logic [3:0] {
    LINK_IDLE = 4'h0,
    LINK_ADDR = 4'h1,
    LINK_ADDR_ACK = 4'h3,
    LINK_PTR = 4'h2,
    LINK_PTR_ACK = 4'h6,
    LINK_WDATA = 4'h7,
    LINK_WDATA_ACK = 4'h5,
    LINK_RDATA = 4'h4,
    LINK_RDATA_ACK = 4'hC
  } link_state_t;
endpackage : pd_status_pkg

// ### tb/i2c_host_model.sv
// Host side of the serial register link: drives SCL, pulls or releases SDA.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`include "pd_status_defs.svh"
module i2c_host_model (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  initial scl = 1'b1;
  initial sda_rel = 1'b1;
  ////////////////////////////////////////////////////////////
  // Waits whole core cycles; each half bit is long so the link syncs keep up
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w
  // Start or stop: data moves while SCL is high, so it is a bus condition
  task automatic cond(input logic b0, input logic b1);
    scl = 1'b0;
    w(5);
    sda_rel = b0;
    w(20);
    scl = 1'b1;
    w(25);
    sda_rel = b1;
    w(25);
  endtask : cond
  // One bit slot; data changes only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    w(5);
    sda_rel = b;
    w(20);
    scl = 1'b1;
    w(25);
    r = sda_line;
  endtask : bit_io
  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, a);
  endtask : xfer
  // Register write: pointer then one data byte
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    cond(1'b1, 1'b0);
    xfer({`TARGET_ADDR, 1'b0}, 1'b1, q, a);
    xfer(ofs, 1'b1, q, a);
    xfer(d, 1'b1, q, a);
    cond(1'b0, 1'b1);
  endtask : wr
  // Two-byte read burst; ack reports the address slot
  task automatic rd(input logic [6:0] ad, input logic [7:0] ofs, output logic [7:0] q0, output logic [7:0] q1,
    output logic ack);
    logic a;
    cond(1'b1, 1'b0);
    xfer({ad, 1'b0}, 1'b1, q0, ack);
    xfer(ofs, 1'b1, q0, a);
    cond(1'b1, 1'b0);
    xfer({ad, 1'b1}, 1'b1, q0, a);
    xfer(8'hFF, 1'b0, q0, a);
    xfer(8'hFF, 1'b1, q1, a); // No-acknowledge ends the burst
    cond(1'b0, 1'b1);
  endtask : rd
endmodule : i2c_host_model

// ### tb/test_pd_port_status_register_bank.sv
// Bench for the status bank: host reads and writes against expected bytes.
// Assumes the host model and the constants header are compiled alongside.
`timescale 1ns/1ps
`include "pd_status_defs.svh"
module test_pd_port_status_register_bank;
  logic core_clk = 0, link_clk = 0, resetn = 0, en = 1, uv = 0, kind = 0, rp = 1, mm = 1, gb = 0, cab = 1;
  logic scl, sda_rel, sda_out, sda_oe, clk_on, ack;
  logic [8:0] ps = '0;
  logic [3:0] ev = '0;
  logic [2:0] idx = '0;
  logic [7:0] volt = 8'h5A, req = 8'h64, q0, q1;
  logic [6:0] cur = 7'h3C;
  int fail_count = 0;
  int compares = 0;
  wire sda = sda_oe ? sda_out : sda_rel; // Pull-up unless the device pulls low
  always #50 core_clk = ~core_clk;
  always #32 link_clk = ~link_clk;
  pd_port_status_register_bank DUT (.core_clk, .resetn, .link_clk, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .sink_present(ps[8]), .second_thermistor_event(ps[7]), .plug_orientation(ps[6]), .battery_short_flag(ps[5]),
    .over_current(ps[4]), .over_temperature(ps[3]), .config_page(ps[2]), .current_limit_state(ps[1]),
    .thermistor_event(ps[0]), .supply_low_first_flag(ev[3]), .supply_low_second_flag(ev[2]),
    .temp_warning_first(ev[1]), .temp_warning_second(ev[0]), .selected_offer_index(idx), .offer_kind(kind),
    .offer_voltage(volt), .offer_current(cur), .pullup_high(rp), .capability_mismatch(mm),
    .power_return_request(gb), .cable_current_rating(cab), .requested_current_limit(req), .enable_ctrl(en),
    .supply_uvlo(uv), .digital_clock_on(clk_on));
  i2c_host_model host (.core_clk, .sda_line(sda), .scl, .sda_rel);
  ////////////////////////////////////////////////////////////
  // Byte compare
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Clock flag compare after a settle time
  task automatic clk_is(input string n, input logic e);
    host.w(8);
    chk(n, {7'h00, e}, {7'h00, clk_on});
  endtask : clk_is
  task automatic rd(input logic [7:0] o);
    host.rd(`TARGET_ADDR, o, q0, q1, ack);
  endtask : rd
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////
  // Clock control first, then every status register
  initial
  begin
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    clk_is("clock_idle", 1'b0);
    host.wr(`CORE_CLOCK_ENABLE_OFS, `CLOCK_ON_CMD);
    clk_is("clock_on", 1'b1);
    rd(`CORE_CLOCK_ENABLE_OFS);
    chk("clock_bit", 8'h00, q0);
    host.wr(`CORE_CLOCK_ENABLE_OFS, `CLOCK_OFF_CMD);
    clk_is("clock_stop", 1'b0);
    ps = 9'h100;
    clk_is("attach_on", 1'b1);
    en = 1'b0;
    clk_is("enable_off", 1'b0);
    en = 1'b1;
    host.wr(`CORE_CLOCK_ENABLE_OFS, `CLOCK_ON_CMD);
    uv = 1'b1;
    clk_is("uvlo_off", 1'b0);
    ps = 9'h155;
    ev = 4'hB;
    idx = 3'h2;
    rd(`CONTRACT_POWER_OFS);
    chk("power", 8'h36, q0);
    chk("suffix", `CONFIG_SUFFIX_VAL, q1);
    ev = 4'h1; // Second warning stays up through the flag read, so its bit must survive the clear
    host.wr(`MAKER_CODE_OFS, 8'hFF);
    rd(`MAKER_CODE_OFS);
    chk("maker", `MAKER_CODE_VAL, q0);
    chk("part", `PART_CODE_VAL, q1);
    rd(`CONFIG_REVISION_OFS);
    chk("revision", `CONFIG_REVISION_VAL, q0);
    rd(`NEGOTIATION_INFO_OFS);
    chk("info", 8'hA3, q0);
    chk("req_current", 8'h64, q1);
    rd(`PORT_STATUS_OFS);
    chk("status", 8'hAD, q0);
    chk("events", 8'hB4, q1);
    {ev, gb, cab, kind, rp, idx, ps} = {4'h0, 4'h8, 3'h0, 9'h0A2};
    rd(`PORT_STATUS_OFS);
    chk("status_b", 8'h5A, q0);
    chk("events_clear", 8'h14, q1);
    rd(`NEGOTIATION_INFO_OFS);
    chk("info_b", 8'hC3, q0);
    chk("req_invalid", 8'h00, q1);
    rd(`EVENT_FLAGS_OFS);
    chk("events_empty", 8'h00, q0);
    chk("power_none", `POWER_DEFAULT_LOW, q1);
    host.rd(7'h62, `PORT_STATUS_OFS, q0, q1, ack);
    chk("wrong_addr", 8'h01, {7'h00, ack});
    results();
  end
endmodule : test_pd_port_status_register_bank
